// *** rtl/tws_exec.v ***
// Function
// - table write lasts two cycles; latch read in Q2, holding write in Q4 of cycle two
// - post-increment writes at current pointer, then pointer plus one; latch kept
// - pre-increment adds one to pointer first, writes at new address only
// - pointer is a 21-bit byte address; its LSB picks low or high byte
// - test skip with zero file value discards prefetched word, runs one NOP cycle, two if it opens a two-word instruction
// - skip over two-word instruction takes three cycles; no skip takes one
// - bank bit 0 picks access bank; 1 combines file address with bank select
// - bank bit 0 with extended set uses indexed offset for file address up to 95
//
// Purpose: executes the table write and test-file-skip-zero instructions
// Assumes: i_instr valid at Q1 of each cycle; file data valid by Q3; i_next_two_word
//          tells whether the prefetched word opens a two-word instruction
// Notes: other pointer modes (none, post-decrement) are also handled for completeness
`timescale 1ns/1ns
`include "tws_defs.vh"
module tws_exec
(
    input wire i_clk,
    input wire i_arst_n,
    input wire [15:0] i_instr,
    input wire i_next_two_word,
    input wire [7:0] i_file_data,
    input wire [7:0] i_table_latch,
    input wire [3:0] i_bank_select_reg,
    input wire [7:0] i_index_base,
    input wire i_ext_set_en,
    input wire [`TWS_HOLD_AW-1:0] i_hold_raddr,
    output reg [1:0] o_q_phase,
    output reg [11:0] o_file_addr,
    output reg o_file_rd,
    output reg o_nop_cycle,
    output reg o_busy,
    output reg [`TWS_PTR_W-1:0] o_table_pointer,
    output reg o_status_we,
    output wire [7:0] o_hold_rdata
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    reg rst_s1_q;
    reg rst_s2_q;
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function is_tblw;
        input [15:0] ins;
        begin
            is_tblw = (ins[15:4] == `TWS_TBLW_HI) && (ins[3:2] == `TWS_TBLW_SUB);
        end
    endfunction

    function is_tst;
        input [15:0] ins;
        begin
            is_tst = (ins[15:12] == `TWS_OP_TST) && (ins[11:9] == `TWS_TST_SUB);
        end
    endfunction

    // access bank, banked space or indexed literal offset
    function [11:0] file_map;
        input a_bit;
        input [7:0] f;
        input ext;
        input [3:0] bank;
        input [7:0] base;
        begin
            if (a_bit)
                file_map = {bank, f};
            else if (ext && (f <= `TWS_IDX_MAX))
                file_map = {4'h0, base} + {4'h0, f};
            else if (f[7])
                file_map = {4'hF, f};
            else
                file_map = {4'h0, f};
        end
    endfunction

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    localparam ST_RUN = 2'h0;
    localparam ST_TBLW2 = 2'h1;
    localparam ST_SKIP1 = 2'h2;
    localparam ST_SKIP2 = 2'h3;

    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [1:0] mode_q;
    reg tst_q;
    // decode is latched at Q1; the instruction word is not held until Q4
    reg tblw_q;
    reg [7:0] latch_q;
    reg hold_we;
    reg [`TWS_PTR_W-1:0] ptr_d;

    wire q1 = (o_q_phase == `TWS_Q1);
    wire q2 = (o_q_phase == `TWS_Q2);
    wire q3 = (o_q_phase == `TWS_Q3);
    wire q4 = (o_q_phase == `TWS_Q4);
    wire run_tst = (st_q == ST_RUN) && tst_q;
    wire zero = (i_file_data == 8'h00);

    always @*
    begin
        st_d = st_q;
        hold_we = 1'b0;
        ptr_d = o_table_pointer;
        case (st_q)
            ST_RUN:
            begin
                if (q4 && run_tst && zero)
                    st_d = ST_SKIP1;
                else if (q4 && tblw_q)
                    st_d = ST_TBLW2;
            end
            ST_TBLW2:
            begin
                if (q4)
                begin
                    hold_we = 1'b1;
                    st_d = ST_RUN;
                    if (mode_q == `TWS_MODE_POST)
                        ptr_d = o_table_pointer + 21'h000001;
                    else if (mode_q == 2'h2)
                        ptr_d = o_table_pointer - 21'h000001;
                end
                else if (q1 && (mode_q == `TWS_MODE_PRE))
                    ptr_d = o_table_pointer + 21'h000001;
            end
            ST_SKIP1:
            begin
                if (q4)
                    st_d = i_next_two_word ? ST_SKIP2 : ST_RUN;
            end
            ST_SKIP2:
            begin
                if (q4)
                    st_d = ST_RUN;
            end
            default:
            begin
                st_d = ST_RUN;
            end
        endcase
    end

    always @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= ST_RUN;
            mode_q <= 2'h0;
            tst_q <= 1'b0;
            tblw_q <= 1'b0;
            latch_q <= 8'h00;
            o_q_phase <= `TWS_Q1;
            o_table_pointer <= `TWS_PTR_RST;
            o_file_addr <= 12'h000;
            o_file_rd <= 1'b0;
            o_nop_cycle <= 1'b0;
            o_busy <= 1'b0;
            o_status_we <= 1'b0;
        end
        else
        begin
            o_q_phase <= o_q_phase + 2'h1;
            st_q <= st_d;
            o_table_pointer <= ptr_d;
            o_status_we <= 1'b0;
            if (q1 && (st_q == ST_RUN))
            begin
                tst_q <= is_tst(i_instr);
                tblw_q <= is_tblw(i_instr);
                mode_q <= i_instr[1:0];
            end
            if (q1 && (st_q == ST_RUN) && is_tst(i_instr))
            begin
                o_file_addr <= file_map(i_instr[8], i_instr[7:0], i_ext_set_en,
                    i_bank_select_reg, i_index_base);
                o_file_rd <= 1'b1;
            end
            else if (q3)
            begin
                o_file_rd <= 1'b0;
            end
            if (q2 && (st_q == ST_TBLW2))
                latch_q <= i_table_latch;
            if (q4)
            begin
                o_nop_cycle <= (st_d == ST_SKIP1) || (st_d == ST_SKIP2);
                o_busy <= (st_d != ST_RUN);
            end
        end
    end

    // ----------------------------------------------------------------
    // holding registers; pointer LSB picks byte lane
    // ----------------------------------------------------------------
    tws_hold_mem u_hold
    (
        .i_clk(i_clk),
        .i_we(hold_we),
        .i_waddr(o_table_pointer[`TWS_HOLD_AW-1:0]),
        .i_wdata(latch_q),
        .i_raddr(i_hold_raddr),
        .o_rdata(o_hold_rdata)
    );
endmodule // tws_exec

// *** rtl/tws_defs.vh ***
// Purpose: constants for the table-write / test-skip execution unit
// Assumes: one instruction cycle is four clocks, phases Q1..Q4
// Notes: definitions only
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH
`define TWS_PTR_W 21
`define TWS_PTR_RST 21'h000000
`define TWS_HOLD_AW 6
`define TWS_Q1 2'h0
`define TWS_Q2 2'h1
`define TWS_Q3 2'h2
`define TWS_Q4 2'h3
`define TWS_OP_TBLW 4'h0
`define TWS_OP_TST 4'h6
`define TWS_TST_SUB 3'h3
`define TWS_MODE_POST 2'h1
`define TWS_MODE_PRE 2'h3
`define TWS_IDX_MAX 8'h5F
`define TWS_TBLW_HI 12'h000
`define TWS_TBLW_SUB 2'h3
`endif

// *** rtl/tws_hold_mem.v ***
// Purpose: flash write holding registers, byte wide
// Assumes: one write port, registered read port
// Notes: depth set by the header constant
`timescale 1ns/1ns
`include "tws_defs.vh"
module tws_hold_mem
(
    input wire i_clk,
    input wire i_we,
    input wire [`TWS_HOLD_AW-1:0] i_waddr,
    input wire [7:0] i_wdata,
    input wire [`TWS_HOLD_AW-1:0] i_raddr,
    output reg [7:0] o_rdata
);
    reg [7:0] mem_q [0:(1<<`TWS_HOLD_AW)-1];
    always @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem_q[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_q[i_raddr];
    end
endmodule // tws_hold_mem

// *** tb/tws_exec_properties.sv ***
// Purpose: port checker for tws_exec
// Assumes: four clocks per instruction cycle
// Notes: bound to every tws_exec
`timescale 1ns/1ns
module tws_exec_properties
(
    input wire i_clk,
    input wire i_arst_n,
    input wire [15:0] i_instr,
    input wire [1:0] o_q_phase,
    input wire o_file_rd,
    input wire o_nop_cycle,
    input wire o_busy,
    input wire [20:0] o_table_pointer,
    input wire o_status_we
);
// ----
// checks
// ----
default clocking @(posedge i_clk); endclocking
default disable iff (!i_arst_n);
a_status_kept: assert property (!o_status_we) else $error("flag write");
a_phase_walk: assert property (o_q_phase != 2'h0 |=>
    o_q_phase == $past(o_q_phase) + 2'h1) else $error("phase");
a_nop_whole: assert property ($rose(o_nop_cycle) |->
    o_q_phase == 2'h0 ##0 o_nop_cycle [*4]) else $error("nop len");
a_nop_busy: assert property (o_nop_cycle |-> o_busy) else $error("nop idle");
a_nop_max: assert property (o_nop_cycle [*8] |=> !o_nop_cycle) else $error("nop long");
a_ptr_step: assert property (!$stable(o_table_pointer) |->
    o_table_pointer == $past(o_table_pointer) + 21'h1) else $error("ptr");
a_read_slot: assert property ($rose(o_file_rd) |->
    o_q_phase == 2'h1 ##1 o_file_rd ##1 !o_file_rd) else $error("read");
a_tbl_busy: assert property (o_q_phase == 2'h0 && !o_busy && i_instr == 16'h000D
    |-> ##[1:5] o_busy) else $error("no 2nd cycle");
endmodule // tws_exec_properties
bind tws_exec tws_exec_properties i_tws_exec_properties (.*);

// *** tb/test_tws_exec.sv ***
// Purpose: random and corner tests of tws_exec
// Assumes: pointer starts at zero, no pointer load port
// Notes: post-decrement mode is not driven
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_tws_exec;
logic clk = 0, rst_n = 0, two = 0, ext = 0;
logic [15:0] ins = 16'hFFFF;
logic [7:0] fd = 0, lat = 0, ibase = 0;
logic [3:0] bank = 0;
logic [5:0] ra = 0;
logic [11:0] e;
logic [20:0] p;
logic [7:0] mem [0:63];
wire [1:0] ph;
wire [11:0] fa;
wire frd, nop, busy;
wire [20:0] ptr;
wire [7:0] hrd;
int error_cnt = 0, check_count = 0, i, n, m, k;
always #50 clk = ~clk;
tws_exec i_tws_exec (.i_clk(clk), .i_arst_n(rst_n), .i_instr(ins), .i_next_two_word(two),
    .i_file_data(fd), .i_table_latch(lat), .i_bank_select_reg(bank), .i_index_base(ibase),
    .i_ext_set_en(ext), .i_hold_raddr(ra), .o_q_phase(ph), .o_file_addr(fa),
    .o_file_rd(frd), .o_nop_cycle(nop), .o_busy(busy), .o_table_pointer(ptr),
    .o_status_we(), .o_hold_rdata(hrd));
// ----
// tasks
// ----
// expected mapped file address: bank bit, indexed window, access bank halves
function automatic logic [11:0] exp_addr(input logic [8:0] r, input logic [3:0] b,
    input logic x, input logic [7:0] base);
    if (r[8])
        exp_addr = {b, r[7:0]};
    else if (x && r[7:0] <= 8'h5F)
        exp_addr = {4'h0, base} + {4'h0, r[7:0]};
    else
        exp_addr = {{4{r[7]}}, r[7:0]};
endfunction
// expected clocks of nop: one cycle per skipped word, four clocks each
function automatic int exp_nops(input logic [7:0] d, input logic t);
    exp_nops = (d == 8'h00) ? (t ? 8 : 4) : 0;
endfunction
// held over two edges so either reading of the Q1 edge sees it, never a third
task issue(input [15:0] w);
    n = 0;
    @(negedge clk);
    while (!(ph === 2'h3 && busy === 1'b0) && n < 40)
    begin
        n++;
        @(negedge clk);
    end
    if (n == 40)
    begin
        error_cnt++;
        $display("[ERR] %0t issue timed out", $time);
    end
    ins = w;
    repeat (2) @(negedge clk);
    ins = 16'hFFFF;
endtask
task tbl(input int pre);
    p = ptr;
    issue(pre ? 16'h000F : 16'h000D);
    repeat (8) @(negedge clk);
    `CHK(ptr, p + 21'h1)
    mem[p[5:0] + 6'(pre)] = lat;
    for (k = 0; k < 2; k++)
    begin
        ra = p[5:0] + k;
        repeat (2) @(negedge clk);
        `CHK(hrd, mem[ra])
    end
endtask
task tst(input [8:0] r);
    e = exp_addr(r, bank, ext, ibase);
    issue({7'h33, r});
    m = 0;
    k = 0;
    repeat (16) @(negedge clk)
    begin
        m += nop;
        if (frd === 1'b1 && k == 0)
        begin
            `CHK(fa, e)
            k = 1;
        end
    end
    `CHK(m, exp_nops(fd, two))
endtask
task report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
initial
begin
    #3000000;
    error_cnt++;
    report_and_stop;
end
initial
begin
    void'($urandom(32'hcff1c5bb));
    repeat (2) @(negedge clk);
    rst_n = 1;
    for (i = 0; i < 40; i++)
    begin
        n = (i < 4) ? i : $urandom % 3;
        bank = $urandom;
        ibase = $urandom % 32;
        ext = (i < 4) ? 1'b1 : $urandom;
        two = $urandom;
        lat = $urandom;
        fd = ($urandom % 2) ? 8'h00 : $urandom;
        if (n < 2)
            tbl(n);
        else
            tst(i == 2 ? 9'h05F : i == 3 ? 9'h060 : $urandom);
        $display("test %0d done", i);
    end
    report_and_stop;
end
endmodule // test_tws_exec
